// *** sim/interrupt_reset_vectoring_props.sv ***
// port timing checks of the vectoring unit
// assumes one clock and the async low reset
module interrupt_reset_vectoring_props #(
    parameter int          N_SRC      = 8,
    parameter logic [13:0] BOOT_START = 14'h3800
) (
    input wire logic                     ref_clk,
    input wire logic                     rst_n,
    input wire irq_unit_pkg::instr_op_s  instr_op,
    input wire logic                     reset_vector_boot_fuse,
    input wire irq_unit_pkg::stack_req_s stack_req,
    input wire logic                     pc_load,
    input wire irq_unit_pkg::pc_t        pc_value,
    input wire logic                     core_hold,
    input wire logic                     core_wake
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic [2:0] since_rst_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_rst_q <= 3'h0;
        end else if (since_rst_q != 3'h7) begin
            since_rst_q <= since_rst_q + 3'h1;
        end
    end
    property p_boot_vector;
        since_rst_q < 3'h4 |-> pc_load == (since_rst_q == 3'h3) &&
            (!pc_load || pc_value == (reset_vector_boot_fuse ? BOOT_START : 14'h0000));
    endproperty
    a_boot_vector: assert property (p_boot_vector)
        else $error("reset vector load wrong");
    property p_entry_push;
        stack_req.we && !$past(stack_req.we) |=> stack_req.we &&
            stack_req.addr == $past(stack_req.addr) - 16'h0001 ##2 pc_load;
    endproperty
    a_entry_push: assert property (p_entry_push)
        else $error("entry push sequence wrong");
    property p_return_pop;
        stack_req.re && !$past(stack_req.re) |=> stack_req.re &&
            stack_req.addr == $past(stack_req.addr) + 16'h0001 ##2 pc_load;
    endproperty
    a_return_pop: assert property (p_return_pop)
        else $error("return pop sequence wrong");
    property p_push_high;
        stack_req.we && $past(stack_req.we) |-> stack_req.wdata[7:6] == 2'b00;
    endproperty
    a_push_high: assert property (p_push_high)
        else $error("high byte too wide");
    property p_load_release;
        pc_load |-> core_hold ##1 !core_hold;
    endproperty
    a_load_release: assert property (p_load_release)
        else $error("hold stuck");
    property p_cli_blocks;
        instr_op.boundary && instr_op.cli && !core_hold |=> !core_hold;
    endproperty
    a_cli_blocks: assert property (p_cli_blocks)
        else $error("entry after clear");
    property p_vector_range;
        pc_load && $past(stack_req.we, 3) |-> pc_value[0] == 1'b0 &&
            (pc_value & ~BOOT_START) >= 14'h0002 &&
            (pc_value & ~BOOT_START) <= 14'(2 * N_SRC);
    endproperty
    a_vector_range: assert property (p_vector_range)
        else $error("vector outside table");
    property p_wake_delay;
        $rose(core_hold) && core_wake |-> !stack_req.we [*5] ##1 stack_req.we;
    endproperty
    a_wake_delay: assert property (p_wake_delay)
        else $error("wake entry delay wrong");
endmodule : interrupt_reset_vectoring_props

bind interrupt_reset_vectoring interrupt_reset_vectoring_props #(
    .N_SRC(N_SRC), .BOOT_START(BOOT_START)
) interrupt_reset_vectoring_props_inst (
    .ref_clk, .rst_n, .instr_op, .reset_vector_boot_fuse, .stack_req,
    .pc_load, .pc_value, .core_hold, .core_wake
);

// *** sim/interrupt_reset_vectoring_tb_top.sv ***
// self-checking bench of the vectoring unit
// assumes the stack model and a 200 MHz clock
`include "irq_unit_cfg.svh"
module interrupt_reset_vectoring_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     ref_clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic [7:0]               reg_addr = 8'h00;
    logic [7:0]               reg_wdata = 8'h00;
    logic                     reg_wr = 1'b0;
    logic                     reg_rd = 1'b0;
    logic [7:0]               reg_rdata;
    logic [7:0]               src_event = 8'h00;
    logic [7:0]               src_level = 8'h00;
    irq_unit_pkg::instr_op_s  instr_op = '0;
    irq_unit_pkg::pc_t        return_pc = 14'h1234;
    logic                     core_asleep = 1'b0;
    logic                     wake_ready = 1'b0;
    logic                     reset_vector_boot_fuse = 1'b0;
    logic                     app_lock_bit_b = 1'b0;
    logic                     boot_lock_bit_b = 1'b0;
    logic [7:0]               stack_rdata;
    irq_unit_pkg::stack_req_s stack_req;
    logic                     pc_load;
    irq_unit_pkg::pc_t        pc_value;
    logic                     core_hold;
    logic                     core_wake;
    int                       miscompares = 0;
    int                       checked = 0;

    always #2.5 ref_clk = ~ref_clk;

    interrupt_reset_vectoring interrupt_reset_vectoring_inst (
        .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .src_event, .src_level, .instr_op, .return_pc, .core_asleep, .wake_ready,
        .reset_vector_boot_fuse, .app_lock_bit_b, .boot_lock_bit_b, .stack_rdata,
        .stack_req, .pc_load, .pc_value, .core_hold, .core_wake
    );
    stack_mem_model stack_mem_model_inst (.ref_clk, .stack_req, .stack_rdata);

    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd
    task automatic pulse(input logic [7:0] m);
        @(posedge ref_clk);
        src_event <= m;
        @(posedge ref_clk);
        src_event <= 8'h00;
    endtask : pulse
    // one boundary once hold drops
    task automatic step(input logic [3:0] op);
        int i;
        for (i = 0; i < 60 && core_hold !== 1'b0; i++) begin
            @(negedge ref_clk);
        end
        if (i == 60) begin
            miscompares++;
            stop_test();
        end
        @(posedge ref_clk);
        instr_op <= irq_unit_pkg::instr_op_s'(op);
        @(posedge ref_clk);
        instr_op <= '0;
        #1;
    endtask : step
    task automatic wait_load(input logic [13:0] exp);
        int i;
        for (i = 0; i < 40 && pc_load !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
        chk({1'b0, pc_load, pc_value}, {2'b01, exp});
        if (i == 40) begin
            stop_test();
        end
    endtask : wait_load
    task automatic idle(input logic [3:0] op);
        step(op);
        chk({15'h0000, core_hold}, 16'h0000);
    endtask : idle
    task automatic take(input logic [3:0] op, input logic [13:0] vec);
        step(op);
        chk({15'h0000, core_hold}, 16'h0001);
        wait_load(vec);
    endtask : take

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_load(14'h0000);
        rd(`OFS_CORE_FLAGS, `RST_CORE_FLAGS);
        rd(`OFS_SP_LO, 8'hFF);
        rd(`OFS_SP_HI, 8'h08);
        rd(`OFS_CORE_CTRL, `RST_CORE_CTRL);
        rd(8'h00, 8'h00);
        pulse(8'h03);
        rd(`OFS_IRQ_PENDING, 8'h03);
        wr(`OFS_IRQ_ENABLE, 8'h03);
        idle(4'h8);
        idle(4'hA);
        idle(4'h8);
        take(4'h8, 14'h0002);
        rd(`OFS_SP_LO, 8'hFD);
        rd(`OFS_CORE_FLAGS, 8'h00);
        rd(`OFS_IRQ_PENDING, 8'h02);
        take(4'hC, 14'h1234);
        rd(`OFS_SP_LO, 8'hFF);
        rd(`OFS_CORE_FLAGS, 8'h80);
        idle(4'h8);
        take(4'h8, 14'h0004);
        take(4'hC, 14'h1234);
        wr(`OFS_IRQ_ENABLE, 8'h04);
        idle(4'h8);
        pulse(8'h04);
        idle(4'h9);
        rd(`OFS_CORE_FLAGS, 8'h00);
        wr(`OFS_IRQ_PENDING, 8'h00);
        rd(`OFS_IRQ_PENDING, 8'h04);
        wr(`OFS_IRQ_PENDING, 8'h04);
        rd(`OFS_IRQ_PENDING, 8'h00);
        // vectors in the boot area, interrupted code below it
        @(posedge ref_clk);
        app_lock_bit_b <= 1'b1;
        return_pc      <= 14'h0100;
        wr(`OFS_CORE_CTRL, 8'h02);
        wr(`OFS_CORE_FLAGS, 8'h80);
        rd(`OFS_CORE_FLAGS, 8'h80);
        wr(`OFS_IRQ_ENABLE, 8'h08);
        pulse(8'h08);
        idle(4'h8);
        @(posedge ref_clk);
        return_pc <= 14'h3900;
        take(4'h8, 14'h3808);
        take(4'hC, 14'h3900);
        idle(4'h8);
        @(posedge ref_clk);
        app_lock_bit_b <= 1'b0;
        src_level      <= 8'h10;
        wr(`OFS_CORE_CTRL, 8'h00);
        rd(`OFS_IRQ_PENDING, 8'h10);
        @(posedge ref_clk);
        src_level <= 8'h00;
        wr(`OFS_IRQ_ENABLE, 8'h10);
        idle(4'h8);
        @(posedge ref_clk);
        src_level <= 8'h10;
        wr(`OFS_IRQ_ENABLE, 8'h11);
        take(4'h8, 14'h000A);
        // handler reopens the global enable
        wr(`OFS_CORE_FLAGS, 8'h80);
        @(posedge ref_clk);
        src_level <= 8'h00;
        pulse(8'h01);
        take(4'h8, 14'h0002);
        rd(`OFS_SP_LO, 8'hFB);
        take(4'hC, 14'h3900);
        take(4'hC, 14'h3900);
        wr(`OFS_IRQ_ENABLE, 8'h02);
        idle(4'h8);
        @(posedge ref_clk);
        core_asleep <= 1'b1;
        pulse(8'h02);
        repeat (3) @(posedge ref_clk);
        #1;
        chk({15'h0000, core_wake}, 16'h0001);
        @(posedge ref_clk);
        wake_ready <= 1'b1;
        wait_load(14'h0004);
        @(posedge ref_clk);
        core_asleep <= 1'b0;
        wake_ready  <= 1'b0;
        take(4'hC, 14'h3900);
        stop_test();
    end
endmodule : interrupt_reset_vectoring_tb_top

// *** sim/stack_mem_model.sv ***
// stack memory model on the far side
// assumes one-cycle reads on the unit's clock
module stack_mem_model (
    input  wire logic                     ref_clk,
    input  wire irq_unit_pkg::stack_req_s stack_req,
    output logic [7:0]                    stack_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [logic [15:0]];
    initial stack_rdata = 8'hA5;
    // stale data toggles so that a late sample never looks valid
    always @(posedge ref_clk) begin
        if (stack_req.we) begin
            mem[stack_req.addr] = stack_req.wdata;
        end
        if (stack_req.re && mem.exists(stack_req.addr)) begin
            stack_rdata <= mem[stack_req.addr];
        end else begin
            stack_rdata <= ~stack_rdata;
        end
    end
endmodule : stack_mem_model

// *** verilog/interrupt_reset_vectoring.sv ***
// interrupt arbitration, vectoring, entry/return sequencing and reset vector
// assumes a same-clock sequencer and a stack memory with one-cycle reads
//
// Contract
// RULE1 - source and global enables both gate a request
// RULE2 - lock bits block requests by program counter region
// RULE3 - lowest vector wins; reset, then external request zero
// RULE4 - vector select and fuse move vectors to boot start
// RULE5 - acceptance clears global enable
// RULE6 - enable set in a handler allows nesting
// RULE7 - return sets global enable
// RULE8 - taking a flagged source vectors and clears its flag
// RULE9 - one written to a flag clears it
// RULE10 - disabled source keeps its flag pending
// RULE11 - flags pending under global disable served later by priority
// RULE12 - level sources request only while present
// RULE13 - one instruction runs after return before entry
// RULE14 - handler software saves the core flags
// RULE15 - clear-global-enable blocks its own boundary
// RULE16 - one instruction runs after set-global-enable before entry
// RULE17 - entry takes four cycles and pushes the program counter
// RULE18 - jump at the vector takes three cycles
// RULE19 - multi-cycle instruction finishes before entry
// RULE20 - wake from sleep adds four cycles
// RULE21 - return takes four cycles, pops two bytes, stack pointer plus two
// RULE22 - program counter and vectors are 14-bit word addresses
// RULE23 - push lowers the stack pointer by two
// RULE24 - global enable is bit 7 of the core flags
// RULE25 - reset clears global enable, loads selected reset vector
//
// The implementer's own choices: the plain strobed port and the address map.
`include "irq_unit_cfg.svh"

module interrupt_reset_vectoring #(
    parameter int          N_SRC      = 8,
    parameter logic [7:0]  LEVEL_MASK = 8'hF0,
    parameter logic [13:0] BOOT_START = 14'h3800
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    input  wire logic [N_SRC-1:0]         src_event,
    input  wire logic [N_SRC-1:0]         src_level,
    input  wire irq_unit_pkg::instr_op_s  instr_op,
    input  wire irq_unit_pkg::pc_t        return_pc,
    input  wire logic                     core_asleep,
    input  wire logic                     wake_ready,
    input  wire logic                     reset_vector_boot_fuse,
    input  wire logic                     app_lock_bit_b,
    input  wire logic                     boot_lock_bit_b,
    input  wire logic [7:0]               stack_rdata,
    output irq_unit_pkg::stack_req_s      stack_req,
    output logic                          pc_load,
    output irq_unit_pkg::pc_t             pc_value,
    output logic                          core_hold,
    output logic                          core_wake
);
    localparam logic [1:0] ENTRY_LAST = 2'(`ENTRY_CYCLES - 1);
    localparam logic [1:0] WAKE_LAST  = 2'(`WAKE_CYCLES - 1);
    localparam logic [1:0] RET_LAST   = 2'(`RET_CYCLES - 1);
    localparam logic [1:0] SYNC_LAST  = 2'(`SYNC_CYCLES);
    // jump at the vector is timed by the sequencer
    localparam int         JUMP_CYCLES = `JUMP_CYCLES; // RULE18

    // lowest index wins, so the lowest vector wins
    function automatic logic [2:0] pick_lowest(input logic [N_SRC-1:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : pick_lowest

    function automatic irq_unit_pkg::pc_t vector_of(input logic [13:0] base,
                                                    input logic [2:0]  idx);
        return base + `VEC_STRIDE * (14'(idx) + 14'h0001); // RULE22
    endfunction : vector_of

    irq_unit_pkg::seq_state_e state_q;
    logic [1:0]               cnt_q;
    logic [N_SRC-1:0]         lvl_meta_q;
    logic [N_SRC-1:0]         lvl_sync_q;
    logic [2:0]               pin_meta_q;
    logic [2:0]               pin_sync_q;
    logic [N_SRC-1:0]         flag_q;
    logic [N_SRC-1:0]         enable_q;
    logic [7:0]               flags_q;
    logic [7:0]               ctrl_q;
    logic [15:0]              sp_q;
    logic                     hold_one_q;
    irq_unit_pkg::pc_t        ret_pc_q;
    irq_unit_pkg::pc_t        vec_q;
    logic [2:0]               src_q;
    logic [7:0]               pop_lo_q;

    logic              fuse_s;
    logic              app_lock_s;
    logic              boot_lock_s;
    logic              gie;
    logic              vec_sel;
    logic [13:0]       vec_base;
    logic [N_SRC-1:0]  pending;
    logic [N_SRC-1:0]  ready_req;
    logic              locked;
    logic              gie_eff;
    logic              take;
    logic              wake_take;
    logic              do_return_from_handler;
    logic [N_SRC-1:0]  hw_clear;
    logic [N_SRC-1:0]  sw_clear;
    logic              wr_flags;
    logic              entry_done;
    logic              ret_done;
    logic [2:0]        win;

    assign fuse_s      = pin_sync_q[0];
    assign app_lock_s  = pin_sync_q[1];
    assign boot_lock_s = pin_sync_q[2];
    assign gie         = flags_q[`BIT_GIE]; // RULE24
    assign vec_sel     = ctrl_q[`BIT_VEC_SEL];
    assign vec_base    = vec_sel ? BOOT_START : 14'h0000; // RULE4

    // level sources carry no flag and vanish with their condition
    assign pending   = (flag_q & ~LEVEL_MASK[N_SRC-1:0])
                     | (lvl_sync_q & LEVEL_MASK[N_SRC-1:0]); // RULE12
    assign ready_req = pending & enable_q; // RULE1 RULE10
    assign win       = pick_lowest(ready_req); // RULE3

    // vectors in one section, code in the other, lock bit set: no entry
    assign locked = (app_lock_s && vec_sel && (return_pc < BOOT_START))
                  || (boot_lock_s && !vec_sel && (return_pc >= BOOT_START)); // RULE2

    // a clear at this boundary beats any request
    assign gie_eff = gie && !(instr_op.boundary && instr_op.cli); // RULE15

    assign do_return_from_handler = (state_q == irq_unit_pkg::ST_RUN) && instr_op.boundary
                   && instr_op.return_from_handler;
    // boundaries only, never right after return or enable
    assign take = (state_q == irq_unit_pkg::ST_RUN) && instr_op.boundary
                && !instr_op.return_from_handler && !core_asleep && gie_eff && !hold_one_q
                && !locked && (|ready_req); // RULE1 RULE13 RULE16 RULE19 RULE6
    assign wake_take = (state_q == irq_unit_pkg::ST_RUN) && core_asleep
                     && wake_ready && gie && !locked && (|ready_req);

    assign entry_done = (state_q == irq_unit_pkg::ST_ENTRY) && (cnt_q == ENTRY_LAST);
    assign ret_done   = (state_q == irq_unit_pkg::ST_RET) && (cnt_q == RET_LAST);

    assign wr_flags = reg_wr && (reg_addr == `OFS_IRQ_PENDING);
    assign sw_clear = wr_flags ? reg_wdata[N_SRC-1:0] : '0;
    always_comb begin
        hw_clear = '0;
        if (entry_done) begin
            hw_clear[src_q] = 1'b1;
        end
    end

    // fuse and lock straps come from pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
            lvl_meta_q <= '0;
            lvl_sync_q <= '0;
        end else begin
            pin_meta_q <= {boot_lock_bit_b, app_lock_bit_b, reset_vector_boot_fuse};
            pin_sync_q <= pin_meta_q;
            lvl_meta_q <= src_level;
            lvl_sync_q <= lvl_meta_q;
        end
    end

    // an event in the cycle of its clear stays set
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~sw_clear & ~hw_clear) | src_event; // RULE8 RULE9 RULE10 RULE11
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= '0;
            ctrl_q   <= `RST_CORE_CTRL;
        end else if (reg_wr) begin
            if (reg_addr == `OFS_IRQ_ENABLE) begin
                enable_q <= reg_wdata[N_SRC-1:0];
            end
            if (reg_addr == `OFS_CORE_CTRL) begin
                ctrl_q <= reg_wdata;
            end
        end
    end

    // flags are never stacked by hardware
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= `RST_CORE_FLAGS; // RULE25
        end else begin
            if (reg_wr && (reg_addr == `OFS_CORE_FLAGS)) begin
                flags_q <= reg_wdata;
            end
            if (instr_op.boundary && instr_op.sei) begin
                flags_q[`BIT_GIE] <= 1'b1;
            end
            if (instr_op.boundary && instr_op.cli) begin
                flags_q[`BIT_GIE] <= 1'b0; // RULE15
            end
            if (ret_done) begin
                flags_q[`BIT_GIE] <= 1'b1; // RULE7 RULE21
            end
            if (take || wake_take) begin
                flags_q[`BIT_GIE] <= 1'b0; // RULE5
            end
        end
    end

    // one instruction must retire after enable or return before entry
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_one_q <= 1'b0;
        end else if (ret_done) begin
            hold_one_q <= 1'b1; // RULE13
        end else if (instr_op.boundary && instr_op.sei) begin
            hold_one_q <= 1'b1; // RULE16
        end else if (instr_op.boundary && (state_q == irq_unit_pkg::ST_RUN)) begin
            hold_one_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= irq_unit_pkg::ST_BOOT;
            cnt_q   <= 2'h0;
        end else begin
            case (state_q)
                irq_unit_pkg::ST_BOOT: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == SYNC_LAST) begin
                        state_q <= irq_unit_pkg::ST_RUN;
                        cnt_q   <= 2'h0;
                    end
                end
                irq_unit_pkg::ST_RUN: begin
                    cnt_q <= 2'h0;
                    if (do_return_from_handler) begin
                        state_q <= irq_unit_pkg::ST_RET;
                    end else if (wake_take) begin
                        state_q <= irq_unit_pkg::ST_WAKE; // RULE20
                    end else if (take) begin
                        state_q <= irq_unit_pkg::ST_ENTRY;
                    end
                end
                irq_unit_pkg::ST_WAKE: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == WAKE_LAST) begin
                        state_q <= irq_unit_pkg::ST_ENTRY; // RULE20
                    end
                end
                irq_unit_pkg::ST_ENTRY: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (entry_done) begin
                        state_q <= irq_unit_pkg::ST_RUN; // RULE17
                    end
                end
                irq_unit_pkg::ST_RET: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (ret_done) begin
                        state_q <= irq_unit_pkg::ST_RUN; // RULE21
                    end
                end
                default: begin
                    state_q <= irq_unit_pkg::ST_BOOT;
                    cnt_q   <= 2'h0;
                end
            endcase
        end
    end

    // winner and return address frozen at acceptance
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_q    <= 3'h0;
            vec_q    <= 14'h0000;
            ret_pc_q <= 14'h0000;
        end else if (take || wake_take) begin
            src_q    <= win;
            vec_q    <= vector_of(vec_base, win); // RULE3 RULE4 RULE8
            ret_pc_q <= return_pc;
        end
    end

    // entry and return win over software writes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= `RST_SP;
        end else if (entry_done) begin
            sp_q <= sp_q - `SP_STEP; // RULE23
        end else if (ret_done) begin
            sp_q <= sp_q + `SP_STEP; // RULE21
        end else if (reg_wr && (reg_addr == `OFS_SP_LO)) begin
            sp_q[7:0] <= reg_wdata;
        end else if (reg_wr && (reg_addr == `OFS_SP_HI)) begin
            sp_q[15:8] <= reg_wdata;
        end
    end

    // push low byte at sp, high at sp-1; pop sp+1 then sp+2
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_req <= '0;
        end else begin
            stack_req <= '0;
            if (state_q == irq_unit_pkg::ST_ENTRY) begin
                if (cnt_q == 2'h0) begin
                    stack_req.we    <= 1'b1; // RULE17
                    stack_req.addr  <= sp_q;
                    stack_req.wdata <= ret_pc_q[7:0];
                end else if (cnt_q == 2'h1) begin
                    stack_req.we    <= 1'b1;
                    stack_req.addr  <= sp_q - `SP_ONE;
                    stack_req.wdata <= {2'h0, ret_pc_q[13:8]};
                end
            end else if (state_q == irq_unit_pkg::ST_RET) begin
                if (cnt_q == 2'h0) begin
                    stack_req.re   <= 1'b1; // RULE21
                    stack_req.addr <= sp_q + `SP_ONE;
                end else if (cnt_q == 2'h1) begin
                    stack_req.re   <= 1'b1;
                    stack_req.addr <= sp_q + `SP_STEP;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pop_lo_q <= `RST_BYTE;
        end else if ((state_q == irq_unit_pkg::ST_RET) && (cnt_q == 2'h2)) begin
            pop_lo_q <= stack_rdata;
        end
    end

    // reset vector is issued once the fuse strap has settled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_load  <= 1'b0;
            pc_value <= 14'h0000;
        end else begin
            pc_load <= 1'b0;
            if ((state_q == irq_unit_pkg::ST_BOOT) && (cnt_q == SYNC_LAST)) begin
                pc_load  <= 1'b1; // RULE25
                pc_value <= fuse_s ? BOOT_START : 14'h0000; // RULE4 RULE25
            end else if (entry_done) begin
                pc_load  <= 1'b1; // RULE17 RULE8
                pc_value <= vec_q;
            end else if (ret_done) begin
                pc_load  <= 1'b1; // RULE21
                pc_value <= {pop_lo_q[5:0], stack_rdata};
            end
        end
    end

    // hold covers boot, wake, entry and return; wake asks for start-up
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_hold <= 1'b1;
            core_wake <= 1'b0;
        end else begin
            core_hold <= do_return_from_handler || take || wake_take
                      || (state_q != irq_unit_pkg::ST_RUN); // RULE19
            core_wake <= core_asleep && gie && !locked && (|ready_req); // RULE20
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `RST_BYTE;
        end else begin
            reg_rdata <= `RST_BYTE;
            if (reg_rd) begin
                case (reg_addr)
                    `OFS_CORE_FLAGS:  reg_rdata <= flags_q; // RULE24
                    `OFS_CORE_CTRL:   reg_rdata <= ctrl_q;
                    `OFS_SP_LO:       reg_rdata <= sp_q[7:0];
                    `OFS_SP_HI:       reg_rdata <= sp_q[15:8];
                    `OFS_IRQ_ENABLE:  reg_rdata <= 8'(enable_q);
                    `OFS_IRQ_PENDING: reg_rdata <= 8'(pending);
                    default:          reg_rdata <= `RST_BYTE;
                endcase
            end
        end
    end

endmodule : interrupt_reset_vectoring

// *** verilog/irq_unit_cfg.svh ***
// constants of the interrupt and reset vectoring unit
// assumes an 8-bit register port and a 14-bit word-addressed program counter
`ifndef IRQ_UNIT_CFG_SVH
`define IRQ_UNIT_CFG_SVH
`define OFS_CORE_FLAGS   8'h5F
`define OFS_SP_LO        8'h5D
`define OFS_SP_HI        8'h5E
`define OFS_CORE_CTRL    8'h55
`define OFS_IRQ_ENABLE   8'h70
`define OFS_IRQ_PENDING  8'h71
`define BIT_GIE          7
`define BIT_VEC_SEL      1
`define RST_CORE_FLAGS   8'h00
`define RST_CORE_CTRL    8'h00
`define RST_SP           16'h08FF
`define RST_BYTE         8'h00
`define ENTRY_CYCLES     4
`define WAKE_CYCLES      4
`define RET_CYCLES       4
`define JUMP_CYCLES      3
`define SP_STEP          16'h0002
`define SP_ONE           16'h0001
`define SYNC_CYCLES      2
`define VEC_STRIDE       14'h0002
`endif

// *** verilog/irq_unit_pkg.sv ***
// types shared by the interrupt and reset vectoring unit
// assumes the cfg header supplies all numeric constants
package irq_unit_pkg;
    typedef enum logic [2:0] {
        ST_BOOT  = 3'h0,
        ST_RUN   = 3'h1,
        ST_WAKE  = 3'h3,
        ST_ENTRY = 3'h2,
        ST_RET   = 3'h6
    } seq_state_e;

    // one instruction ends; op bits qualify it
    typedef struct packed {
        logic boundary;
        logic return_from_handler;
        logic sei;
        logic cli;
    } instr_op_s;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } stack_req_s;

    typedef logic [13:0] pc_t;
endpackage : irq_unit_pkg
